/* hdl/dasr_regs.svh */
`ifndef DASR_REGS_SVH
`define DASR_REGS_SVH
// ****************************************
// Register offsets
// ****************************************
`define DASR_OFF_CORE_CONFIG 4'h0
`define DASR_OFF_TRAP_CTRL   4'h1
`define DASR_OFF_STATUS      4'h2
`define DASR_OFF_WB_PTR      4'h3
`define DASR_OFF_ACC_BASE    4'h4
// ****************************************
// Field positions
// ****************************************
`define DASR_CFG_SAT_A       7
`define DASR_CFG_SAT_B       6
`define DASR_CFG_DW_SAT      5
`define DASR_CFG_SAT_WIDTH   4
`define DASR_CFG_ROUND_MODE  1
`define DASR_TRP_OVF_A       0
`define DASR_TRP_OVF_B       1
`define DASR_TRP_CATA        2
`define DASR_ST_GUARD_A      0
`define DASR_ST_STICKY_A     2
`define DASR_ST_ANY_GUARD    4
`define DASR_ST_ANY_STICKY   5
// ****************************************
// Reset values and constants
// ****************************************
`define DASR_RST_CFG         16'h0000
`define DASR_RST_TRAP        16'h0000
`define DASR_RST_PTR         16'h0000
`define DASR_MAX40           40'h7fffffffff
`define DASR_MIN40           40'h8000000000
`define DASR_MAX32           40'h007fffffff
`define DASR_MIN32           40'hff80000000
`define DASR_DW_MAX          16'h7fff
`define DASR_DW_MIN          16'h8000
`define DASR_DW_POS_LIM      24'h007fff
`define DASR_DW_NEG_LIM      24'hff8000
`define DASR_HALF_LSW        16'h8000
`define DASR_PTR_STEP        16'h0002
`endif

/* hdl/dasr_pkg.sv */
package dasr_pkg;
  // ****************************************
  // Operation codes from the decoder
  // ****************************************
  typedef enum logic [3:0] {
    OP_NOP, OP_CLR, OP_ADD, OP_SUB, OP_LOAD, OP_MULT_ACC, OP_MSC,
    OP_MULT, OP_MULT_NEG, OP_EUCLID, OP_EUCLID_ACC, OP_STORE_TRUNC, OP_STORE_ROUND
  } dasr_op_e;

  // One decoded request per cycle
  typedef struct packed {
    logic        valid;       // Request present
    dasr_op_e    op;          // Operation
    logic        sel_b;       // Target accumulator B
    logic [39:0] operand;     // Product or data, sign extended
    logic [4:0]  shift;       // Signed scale, positive shifts right
    logic        wb_en;       // Non-target write-back wanted
    logic        wb_indirect; // Write through pointer, then step
    logic [15:0] addr;        // Store address
  } dasr_req_s;

  // Data space write
  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic [15:0] data;
  } dasr_dw_s;
endpackage

/* hdl/dasr_acc.sv */
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "dasr_regs.svh"
module dasr_acc #(
  parameter int DATA_W = 16,
  parameter int ACC_W  = 40
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic [3:0]        addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic [DATA_W-1:0]      rdata,
  input  wire dasr_pkg::dasr_req_s req,
  output dasr_pkg::dasr_dw_s     dw,
  output logic                   trap_req,
  output logic                   any_guard_ovf,
  output logic                   any_sat_sticky
);

  // ****************************************
  // Elaboration check
  // ****************************************
  // The datapath is laid out for a 16-bit word and 40-bit accumulator
  if (DATA_W != 16 || ACC_W != 40) begin : g_bad_width
    $error("dasr_acc supports only 16-bit data and 40-bit accumulators");
  end

  // ****************************************
  // State
  // ****************************************
  logic [39:0] acc [2];              // Accumulators A and B
  logic [1:0]  guard_ovf;            // Guard overflow per accumulator
  logic [1:0]  sat_sticky;           // Sticky saturation per accumulator
  logic [15:0] core_config_reg;      // Saturation and rounding control
  logic [15:0] trap_control_reg;     // Trap enables
  logic [15:0] writeback_pointer;    // Write-back pointer

  // Config fields
  wire acc_a_sat_enable = core_config_reg[`DASR_CFG_SAT_A];
  wire acc_b_sat_enable = core_config_reg[`DASR_CFG_SAT_B];
  wire data_write_sat_enable = core_config_reg[`DASR_CFG_DW_SAT];
  wire sat_width_select = core_config_reg[`DASR_CFG_SAT_WIDTH];
  wire round_mode_select = core_config_reg[`DASR_CFG_ROUND_MODE];
  wire acc_a_ovf_trap_enable = trap_control_reg[`DASR_TRP_OVF_A];
  wire acc_b_ovf_trap_enable = trap_control_reg[`DASR_TRP_OVF_B];
  wire catastrophic_trap_enable = trap_control_reg[`DASR_TRP_CATA];

  // ****************************************
  // Operation decode
  // ****************************************
  wire op_vld = req.valid;
  // Decodes below are gated by the valid bit where they act
  // Any pass through the adder
  wire is_pass = op_vld && (req.op != dasr_pkg::OP_NOP)
               && (req.op != dasr_pkg::OP_STORE_TRUNC)
               && (req.op != dasr_pkg::OP_STORE_ROUND);
  // One adder side forced to zero
  wire zero_a = (req.op == dasr_pkg::OP_LOAD) || (req.op == dasr_pkg::OP_MULT)
              || (req.op == dasr_pkg::OP_MULT_NEG) || (req.op == dasr_pkg::OP_EUCLID)
              || (req.op == dasr_pkg::OP_CLR);
  // Subtracting operations
  wire is_sub = (req.op == dasr_pkg::OP_SUB) || (req.op == dasr_pkg::OP_MSC)
              || (req.op == dasr_pkg::OP_MULT_NEG);
  // Only add and load take the shifter scale
  wire is_scaled = (req.op == dasr_pkg::OP_ADD) || (req.op == dasr_pkg::OP_LOAD);
  // Operations allowed to write back the other accumulator
  wire wb_class = (req.op == dasr_pkg::OP_MULT_ACC) || (req.op == dasr_pkg::OP_MSC)
                || (req.op == dasr_pkg::OP_CLR);
  wire do_wb = op_vld && wb_class && req.wb_en;
  wire do_store = op_vld && ((req.op == dasr_pkg::OP_STORE_TRUNC)
                || (req.op == dasr_pkg::OP_STORE_ROUND));

  // ****************************************
  // Operand scaling
  // ****************************************
  wire [4:0]  sh_left = 5'h00 - req.shift;          // Magnitude of left shift
  wire [39:0] sh_r = $signed(req.operand) >>> req.shift;
  wire [39:0] sh_l = req.operand << sh_left;
  // Scaled operand for add and load only
  wire [39:0] opnd = !is_scaled ? req.operand
                   : (req.shift[4] ? sh_l : sh_r);
  // Clear loads zero regardless of operand
  wire [39:0] opnd_z = (req.op == dasr_pkg::OP_CLR) ? 40'h0000000000 : opnd;

  // ****************************************
  // Adder / subtracter
  // ****************************************
  wire [39:0] src = acc[req.sel_b];
  wire [39:0] a_in = zero_a ? 40'h0000000000 : src;
  // Complement for subtract; the borrow-in is inactive, so carry-in is 1
  wire [39:0] b_in = is_sub ? ~opnd_z : opnd_z;
  wire        c_in = is_sub;
  wire [39:0] sum = a_in + b_in + {39'h0, c_in};
  // Sign destroyed: like-signed inputs gave a flipped sign
  wire ovf39 = (a_in[39] == b_in[39]) && (sum[39] != a_in[39]);
  // Result no longer fits a 1.31 value
  wire ovf31 = !(&sum[39:31]) && (|sum[39:31]);
  // True sign of the exact result
  wire neg = ovf39 ? ~sum[39] : sum[39];

  // ****************************************
  // Accumulator saturation
  // ****************************************
  wire sat_en = req.sel_b ? acc_b_sat_enable : acc_a_sat_enable;
  wire mode40 = sat_en && sat_width_select;
  wire mode32 = sat_en && !sat_width_select;
  wire hit32 = mode32 && (ovf39 || ovf31);
  wire hit40 = mode40 && ovf39;
  // Sticky cause: clamp in 32-bit mode, else bit 39 overflow
  wire sticky_set = mode32 ? hit32 : ovf39;
  // Value written to the target
  wire [39:0] result = hit40 ? (neg ? `DASR_MIN40 : `DASR_MAX40)
                     : hit32 ? (neg ? `DASR_MIN32 : `DASR_MAX32)
                     : sum;
  // Guard bits unused in 32-bit saturation mode
  wire guard_new = !mode32 && !(&result[39:32])
                 && (|result[39:32]);

  // ****************************************
  // Round and write saturation
  // ****************************************
  // Write-back reads the other accumulator, a store reads the target
  wire [39:0] rsrc = do_wb ? acc[~req.sel_b] : acc[req.sel_b];
  // Write-back always rounds; store follows its variant
  wire do_round = do_wb || (req.op == dasr_pkg::OP_STORE_ROUND);
  wire tie = (rsrc[15:0] == `DASR_HALF_LSW);
  // Convergent tie only rounds up when bit 16 is set
  wire inc_conv = rsrc[15] && (!tie || rsrc[16]);
  wire inc_conv_sel = round_mode_select ? inc_conv : rsrc[15];
  wire inc = do_round && inc_conv_sel;
  // Keep 24 bits so the round carry into the guard byte is seen
  wire [23:0] r24 = rsrc[39:16] + {23'h0, inc};
  wire dw_pos = !rsrc[39] && (r24 > `DASR_DW_POS_LIM);
  wire dw_neg = rsrc[39] && (r24 < `DASR_DW_NEG_LIM);
  wire [15:0] wr_val = !data_write_sat_enable ? r24[15:0]
                     : dw_pos ? `DASR_DW_MAX
                     : dw_neg ? `DASR_DW_MIN
                     : r24[15:0];

  // ****************************************
  // Register bus decode
  // ****************************************
  wire sel_cfg = (addr == `DASR_OFF_CORE_CONFIG);
  wire sel_trp = (addr == `DASR_OFF_TRAP_CTRL);
  wire sel_st = (addr == `DASR_OFF_STATUS);
  wire sel_ptr = (addr == `DASR_OFF_WB_PTR);
  // Accumulator words: 4..6 for A, 7..9 for B, low word first
  wire [3:0] acc_idx = addr - `DASR_OFF_ACC_BASE;
  wire acc_hit = (addr >= `DASR_OFF_ACC_BASE) && (acc_idx < 4'h6);
  wire acc_pick = (acc_idx >= 4'h3);
  wire [3:0] word_idx = acc_pick ? acc_idx - 4'h3 : acc_idx;
  wire [39:0] acc_rd = acc[acc_pick];
  wire [15:0] acc_word = (word_idx == 4'h0) ? acc_rd[15:0]
                       : (word_idx == 4'h1) ? acc_rd[31:16]
                       : {8'h00, acc_rd[39:32]};
  // Software clears sticky bits by writing ones
  wire [1:0] sticky_clr = (wr && sel_st)
                        ? wdata[`DASR_ST_STICKY_A+1:`DASR_ST_STICKY_A] : 2'h0;
  // Combined bits come straight from the lane flags
  wire [15:0] status_word = {10'h000, |sat_sticky, |guard_ovf,
                             sat_sticky, guard_ovf};
  // Unmapped addresses read zero
  wire [15:0] rd_mux = sel_cfg ? core_config_reg
                     : sel_trp ? trap_control_reg
                     : sel_st ? status_word
                     : sel_ptr ? writeback_pointer
                     : acc_hit ? acc_word : 16'h0000;

  // ****************************************
  // Control registers
  // ****************************************
  // Config and trap enables, software written
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      core_config_reg <= `DASR_RST_CFG;
      trap_control_reg <= `DASR_RST_TRAP;
    end else begin
      if (wr && sel_cfg) begin
        core_config_reg <= wdata;
      end
      if (wr && sel_trp) begin
        trap_control_reg <= wdata;
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata <= 16'h0000;
    end else begin
      rdata <= rd ? rd_mux : 16'h0000;
    end
  end

  // ****************************************
  // Accumulators and flags, one per lane
  // ****************************************
  for (genvar i = 0; i < 2; i++) begin : g_acc
    // This lane is the target of the current pass
    wire tgt = is_pass && (req.sel_b == 1'(i));
    // Accumulator update
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        acc[i] <= 40'h0000000000;
      end else if (tgt) begin
        acc[i] <= result;
      end
    end
    // Guard flag tracks the latest pass of this lane only
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        guard_ovf[i] <= 1'b0;
      end else if (tgt) begin
        guard_ovf[i] <= guard_new;
      end
    end
    // Sticky flag: a set in the clearing cycle wins
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        sat_sticky[i] <= 1'b0;
      end else if (tgt && sticky_set) begin
        sat_sticky[i] <= 1'b1;
      end else if (sticky_clr[i]) begin
        sat_sticky[i] <= 1'b0;
      end
    end
  end

  // ****************************************
  // Flag outputs and trap request
  // ****************************************
  // Catastrophic trap only for a lane without saturation
  wire cat_a = sat_sticky[0] && !acc_a_sat_enable;
  wire cat_b = sat_sticky[1] && !acc_b_sat_enable;
  wire next_trap = (guard_ovf[0] && acc_a_ovf_trap_enable)
                 || (guard_ovf[1] && acc_b_ovf_trap_enable)
                 || (catastrophic_trap_enable && (cat_a || cat_b));
  // Next state of each lane's flags; the combined copies follow it, so they
  // never lag the lane flags by a cycle
  // Plain vector terms: a function called from a continuous assignment
  // would only be re-evaluated when its arguments change
  wire [1:0] lane_tgt = {is_pass && req.sel_b, is_pass && !req.sel_b};
  wire [1:0] next_guard = (lane_tgt & {2{guard_new}})
                        | (~lane_tgt & guard_ovf);
  // A set in the clearing cycle wins over the software clear
  wire [1:0] next_sticky = (lane_tgt & {2{sticky_set}})
                         | (~sticky_clr & sat_sticky);
  wire next_any_guard = |next_guard;
  wire next_any_sticky = |next_sticky;

  // Registered status outputs
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      any_guard_ovf <= 1'b0;
      any_sat_sticky <= 1'b0;
      trap_req <= 1'b0;
    end else begin
      any_guard_ovf <= next_any_guard;
      any_sat_sticky <= next_any_sticky;
      trap_req <= next_trap;
    end
  end

  // ****************************************
  // Write-back pointer and data write port
  // ****************************************
  // Direct write-back lands in the pointer itself
  wire wb_direct = do_wb && !req.wb_indirect;
  wire wb_ind = do_wb && req.wb_indirect;
  // Hardware update outranks a software write in the same cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      writeback_pointer <= `DASR_RST_PTR;
    end else if (wb_direct) begin
      writeback_pointer <= wr_val;
    end else if (wb_ind) begin
      writeback_pointer <= writeback_pointer + `DASR_PTR_STEP;
    end else if (wr && sel_ptr) begin
      writeback_pointer <= wdata;
    end
  end

  // Data space write, one-cycle pulse
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dw <= '0;
    end else begin
      dw.valid <= wb_ind || do_store;
      dw.addr <= wb_ind ? writeback_pointer : req.addr;
      dw.data <= wr_val;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_sticky_hold: assert property (sat_sticky[0] && !sticky_clr[0] |=> sat_sticky[0])
    else $error("sticky flag A dropped without a software clear");
  a_combined_or: assert property (any_guard_ovf == |guard_ovf
                                  && any_sat_sticky == |sat_sticky)
    else $error("combined flags differ from OR of lane flags");
  a_sat40_clamp: assert property (is_pass && !req.sel_b && hit40 && !neg
                                  |=> acc[0] == `DASR_MAX40 && sat_sticky[0])
    else $error("40-bit positive clamp missing");
  a_sat32_guard: assert property (is_pass && !req.sel_b && mode32
                                  |=> !guard_ovf[0] && (&acc[0][39:31] || !(|acc[0][39:31])))
    else $error("32-bit mode left guard flag or bad value");
  a_guard_track: assert property (is_pass && req.sel_b && !mode32
                                  |=> guard_ovf[1] == (acc[1][39:32] != 8'h00
                                                       && acc[1][39:32] != 8'hff))
    else $error("guard flag B does not match guard bits");
  a_lane_indep: assert property (is_pass && req.sel_b |=> $stable(guard_ovf[0])
                                  && $stable(acc[0]))
    else $error("pass on B disturbed accumulator A");
  a_trap_guard: assert property (guard_ovf[0] && acc_a_ovf_trap_enable |=> trap_req)
    else $error("guard trap not requested");
  a_ptr_step: assert property (wb_ind |=> dw.valid && dw.addr == $past(writeback_pointer)
                               && writeback_pointer == $past(writeback_pointer) + 16'h0002)
    else $error("pointer write-back step wrong");
  a_dw_sat_pos: assert property (do_store && data_write_sat_enable && dw_pos
                                 |=> dw.data == `DASR_DW_MAX)
    else $error("positive write saturation missing");
  a_dw_sat_neg: assert property (do_store && data_write_sat_enable && dw_neg
                                 |=> dw.data == `DASR_DW_MIN)
    else $error("negative write saturation missing");
  a_wb_direct: assert property (wb_direct
                                |=> writeback_pointer == $past(wr_val) && !dw.valid)
    else $error("direct write-back did not land in the pointer");
  a_trap_cat: assert property (catastrophic_trap_enable && cat_a |=> trap_req)
    else $error("catastrophic trap not requested");
  a_conv_tie: assert property (do_store && do_round && round_mode_select && tie
                               && !rsrc[16] && !data_write_sat_enable
                               |=> dw.data == $past(rsrc[31:16]))
    else $error("convergent tie rounded up on even word");

  // Main scenarios; the bench reaches all but c_sticky_race
  c_wb_indirect: cover property (wb_ind ##1 dw.valid);
  c_sat40_hit: cover property (is_pass && hit40);
  c_trap_cat: cover property (catastrophic_trap_enable && cat_a ##1 trap_req);
  c_sticky_race: cover property (is_pass && sticky_set && |sticky_clr);
  c_dw_neg: cover property (do_store && data_write_sat_enable && dw_neg);
endmodule

/* test/dasr_dmem.sv */
`timescale 1ns/1ps
// ****************************************
// Data space memory side of the write bus
// ****************************************
module dasr_dmem (
  input wire logic                sys_clk,
  input wire logic                rst,
  input wire dasr_pkg::dasr_dw_s  dw
);
  logic [15:0] last_addr; // Latest write address
  logic [15:0] last_data; // Latest write data
  int unsigned n_writes;  // Writes taken, exposes stray pulses
  // Memory never stalls, so each pulse counts exactly once
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      n_writes <= 0;
    end else if (dw.valid) begin
      last_addr <= dw.addr;
      last_data <= dw.data;
      n_writes  <= n_writes + 1;
    end
  end
endmodule

/* test/testbench.sv */
`timescale 1ns/1ps
module testbench;
  // ****************************************
  // Stimulus and observed signals
  // ****************************************
  logic                sys_clk = 1'b0;
  logic                rst = 1'b1;
  logic [3:0]          addr = 4'h0;
  logic [15:0]         wdata = 16'h0000;
  logic                wr = 1'b0;
  logic                rd = 1'b0;
  logic [15:0]         rdata;
  dasr_pkg::dasr_req_s req = '0;
  dasr_pkg::dasr_dw_s  dw;
  logic                trap_req;
  logic                any_guard_ovf;
  logic                any_sat_sticky;
  int                  fail_count = 0;
  int                  n_checks = 0;
  logic [39:0]         acc;  // Accumulator readback
  logic [15:0]         word; // Register readback
  int unsigned         nw;   // Write count snapshot

  always #12.5 sys_clk = ~sys_clk;

  dasr_acc u_dasr_acc (.sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .req(req), .dw(dw), .trap_req(trap_req),
    .any_guard_ovf(any_guard_ovf), .any_sat_sticky(any_sat_sticky));
  dasr_dmem u_dasr_dmem (.sys_clk(sys_clk), .rst(rst), .dw(dw));

  // ****************************************
  // Shared tasks
  // ****************************************
  task chk(input logic [39:0] seen, input logic [39:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task wreg(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task rreg(input logic [3:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task racc(input logic b, output logic [39:0] v);
    logic [15:0] lo, hi, up;
    rreg(b ? 4'h7 : 4'h4, lo);
    rreg(b ? 4'h8 : 4'h5, hi);
    rreg(b ? 4'h9 : 4'h6, up);
    v = {up[7:0], hi, lo};
  endtask
  // One decoded request; returns once any write pulse has landed
  task op(input dasr_pkg::dasr_op_e o, input logic b, input logic [39:0] v,
          input logic [4:0] sh = 5'h00, input logic [1:0] wb = 2'h0);
    @(posedge sys_clk);
    req <= '{valid: 1'b1, op: o, sel_b: b, operand: v, shift: sh,
             wb_en: wb[1], wb_indirect: wb[0], addr: 16'h0100};
    @(posedge sys_clk);
    req.valid <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  task store(input logic rnd, input logic [15:0] exp);
    nw = u_dasr_dmem.n_writes;
    op(rnd ? dasr_pkg::OP_STORE_ROUND : dasr_pkg::OP_STORE_TRUNC, 1'b0, 40'h0);
    chk(u_dasr_dmem.n_writes - nw, 40'h1);
    chk(u_dasr_dmem.last_data, exp);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task t_reset;
    rreg(4'h0, word); chk(word, 16'h0000);
    rreg(4'h2, word); chk(word, 16'h0000);
    rreg(4'hf, word); chk(word, 16'h0000); // Unmapped reads as zero
  endtask
  task t_adder;
    op(dasr_pkg::OP_LOAD, 1'b0, 40'h0000000010, 5'h01);
    racc(1'b0, acc); chk(acc, 40'h0000000008);
    op(dasr_pkg::OP_ADD, 1'b0, 40'h0000000100);
    op(dasr_pkg::OP_SUB, 1'b0, 40'h0000000200);
    racc(1'b0, acc); chk(acc, 40'hffffffff08);
    racc(1'b1, acc); chk(acc, 40'h0000000000);
  endtask
  // Left scale, unscaled subtract forms and clear, over both lanes
  task t_misc;
    op(dasr_pkg::OP_LOAD, 1'b1, 40'h0000000100, 5'h1f);
    op(dasr_pkg::OP_MSC, 1'b1, 40'h0000000080, 5'h1f);
    racc(1'b1, acc);
    chk(acc, 40'h0000000180);
    op(dasr_pkg::OP_MULT_NEG, 1'b0, 40'h0000000005);
    racc(1'b0, acc);
    chk(acc, 40'hfffffffffb);
    op(dasr_pkg::OP_CLR, 1'b1, 40'h0000001234);
    racc(1'b1, acc);
    chk(acc, 40'h0000000000);
  endtask
  task t_guard(input logic b);
    wreg(4'h1, b ? 16'h0002 : 16'h0001);
    op(dasr_pkg::OP_LOAD, b, 40'h0100000000);
    rreg(4'h2, word); chk(word, b ? 16'h0012 : 16'h0011);
    chk(trap_req, 1'b1);
    wreg(4'h1, 16'h0000);
    op(dasr_pkg::OP_LOAD, b, 40'h0000000001);
    chk({trap_req, any_guard_ovf}, 2'h0);
  endtask
  task t_cata;
    wreg(4'h1, 16'h0004);
    op(dasr_pkg::OP_LOAD, 1'b0, 40'h7fffffffff);
    op(dasr_pkg::OP_ADD, 1'b0, 40'h0000000001);
    racc(1'b0, acc); chk(acc, 40'h8000000000);
    rreg(4'h2, word); chk(word, 16'h0035);
    chk({trap_req, any_sat_sticky}, 2'h3);
    op(dasr_pkg::OP_LOAD, 1'b0, 40'h0000000000);
    rreg(4'h2, word); chk(word, 16'h0024);
    wreg(4'h2, 16'h0004);
    wreg(4'h1, 16'h0000);
    rreg(4'h2, word); chk(word, 16'h0000);
  endtask
  // Reset in mid-run drops flags, trap enables and accumulator A
  task t_rst_mid;
    wreg(4'h1, 16'h0004);
    op(dasr_pkg::OP_LOAD, 1'b0, 40'h7fffffffff);
    op(dasr_pkg::OP_ADD, 1'b0, 40'h0000000001);
    chk({trap_req, any_guard_ovf, any_sat_sticky}, 3'h7);
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rreg(4'h1, word);
    chk(word, 16'h0000);
    rreg(4'h2, word);
    chk(word, 16'h0000);
    chk({trap_req, any_guard_ovf, any_sat_sticky}, 3'h0);
    racc(1'b0, acc);
    chk(acc, 40'h0000000000);
  endtask
  // Clamp both ways in one width mode, then drop the sticky bit
  task t_sat(input logic [15:0] cfg, input logic [39:0] mx, input logic [39:0] mn);
    wreg(4'h0, cfg);
    op(dasr_pkg::OP_LOAD, 1'b0, mx);
    op(dasr_pkg::OP_ADD, 1'b0, 40'h0000000001);
    racc(1'b0, acc); chk(acc, mx);
    rreg(4'h2, word); chk(word[2], 1'b1);
    if (!cfg[4]) chk(word[0], 1'b0);
    op(dasr_pkg::OP_LOAD, 1'b0, mn);
    op(dasr_pkg::OP_SUB, 1'b0, 40'h0000000001);
    racc(1'b0, acc); chk(acc, mn);
    wreg(4'h2, 16'h0004);
    wreg(4'h0, 16'h0000);
  endtask
  task t_round;
    op(dasr_pkg::OP_LOAD, 1'b0, 40'h0000028000);
    store(1'b0, 16'h0002);
    store(1'b1, 16'h0003);
    wreg(4'h0, 16'h0002);
    store(1'b1, 16'h0002);
    op(dasr_pkg::OP_LOAD, 1'b0, 40'h0000038000);
    store(1'b1, 16'h0004);
    op(dasr_pkg::OP_LOAD, 1'b0, 40'h0000027fff);
    store(1'b1, 16'h0002);
    wreg(4'h0, 16'h0000);
  endtask
  task t_dwsat;
    for (int i = 0; i < 2; i++) begin
      wreg(4'h0, i ? 16'h0000 : 16'h0020);
      op(dasr_pkg::OP_LOAD, 1'b0, 40'h0080000000);
      store(1'b0, i ? 16'h8000 : 16'h7fff);
      op(dasr_pkg::OP_LOAD, 1'b0, 40'hff7fff0000);
      store(1'b0, i ? 16'h7fff : 16'h8000);
    end
    racc(1'b0, acc); chk(acc, 40'hff7fff0000);
  endtask
  task t_wb;
    dasr_pkg::dasr_op_e nowb[4];
    nowb = '{dasr_pkg::OP_MULT, dasr_pkg::OP_MULT_NEG,
             dasr_pkg::OP_EUCLID, dasr_pkg::OP_EUCLID_ACC};
    op(dasr_pkg::OP_LOAD, 1'b1, 40'h0000058000);
    wreg(4'h3, 16'h0200);
    nw = u_dasr_dmem.n_writes;
    op(dasr_pkg::OP_MULT_ACC, 1'b0, 40'h0000000010, 5'h00, 2'h3);
    chk({u_dasr_dmem.last_addr, u_dasr_dmem.last_data}, 32'h02000006);
    rreg(4'h3, word); chk(word, 16'h0202);
    op(dasr_pkg::OP_MULT_ACC, 1'b0, 40'h0000000010, 5'h00, 2'h2);
    rreg(4'h3, word); chk(word, 16'h0006);
    // Excluded forms must leave the data space untouched
    foreach (nowb[k]) op(nowb[k], 1'b0, 40'h0000000010, 5'h00, 2'h3);
    chk(u_dasr_dmem.n_writes - nw, 40'h1);
  endtask

  // ****************************************
  // Sequence and hang guard
  // ****************************************
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset;
    t_adder;
    t_misc;
    t_guard(1'b0);
    t_guard(1'b1);
    t_cata;
    t_rst_mid;
    t_sat(16'h0090, 40'h7fffffffff, 40'h8000000000);
    t_sat(16'h0080, 40'h007fffffff, 40'hff80000000);
    t_round;
    t_dwsat;
    t_wb;
    conclude;
  end
  // A stuck sequence counts as a mismatch, not a silent pass
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    conclude;
  end
endmodule
